/* File: hw/nvu_nested_vectored_irq_unit.sv */
// Notes on behaviour
// R1: Interrupt inputs are vectors 16 to 47; entry address is vector times four.
// R2: Bit n is vector n plus 16; bit 0 low voltage, bit 1 watchdog.
// R3: Both serial ports share bit 12; bits 16,17,20,21,23,27 carry nothing.
// R4: Power-down wake-up request drives bit 28, vector 44.
// R5: Clock fail and trim request drives bit 30, vector 46.
// R6: Real-time clock request drives bit 31, vector 47.
// R7: Writing ones sets or clears enables; zero bits change nothing.
// R8: Both enable registers read back the current enable state.
// R9: An asserted disabled interrupt becomes pending but not active.
// R10: An active interrupt stays active after disable until reset or return.
// R11: A disabled interrupt never starts a new activation.
// R12: Writing ones sets or clears pending state; zero bits do nothing.
// R13: Both pending registers read back the current pending state.
// R14: Clearing pending never changes an interrupt's active state.
// R15: Each interrupt has an 8-bit priority field, four per register.
// R16: All registers are memory mapped in the system control space.
// R17: Four priority levels, 0 most urgent; all reset to 0.
// R18: Reset, NMI and hard fault outrank every configurable level.
// R19: Preemption happens only for a strictly higher priority.
// R20: Only the top two bits of each priority field exist.
// R21: Accepting an interrupt clears its pending state.
`timescale 1ns/10ps
`default_nettype none
`include "nvu_regs.svh"

module nvu_nested_vectored_irq_unit
  import nvu_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire nvu_bus_t bus,
  output logic [31:0] rdata_q,
  input wire nvu_src_t src,
  input wire nvu_core_ret_t ret,
  output nvu_core_req_t core_req_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Source mapping.

  logic [31:0] src_w;
  logic [31:0] rsvd_w;

  assign rsvd_w = `NVU_RSVD_MASK;
  assign src_w[`NVU_BIT_LVD] = src.low_voltage_detect_irq; // R2
  assign src_w[`NVU_BIT_WDT] = src.window_watchdog_irq; // R2
  assign src_w[11:2] = src.other_irq[11:2];
  assign src_w[`NVU_BIT_SERIAL] = src.serial0_irq | src.serial2_irq; // R3
  assign src_w[27:13] = src.other_irq[27:13] & ~rsvd_w[27:13]; // R3
  assign src_w[`NVU_BIT_PWRWU] = src.power_down_wakeup_irq; // R4
  assign src_w[29] = src.other_irq[29];
  assign src_w[`NVU_BIT_CLKFAIL] = src.clock_fail_trim_irq; // R5
  assign src_w[`NVU_BIT_RTC] = src.rtc_irq; // R6

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.

  logic [31:0] en_q;
  logic [31:0] pend_q;
  logic [31:0] act_q;
  logic [1:0] pri_q [32];
  logic [31:0] en_d;
  logic [31:0] pend_d;
  logic [31:0] act_d;

  logic hit_setena_w;
  logic hit_clrena_w;
  logic hit_setpend_w;
  logic hit_clrpend_w;
  logic hit_active_w;
  logic hit_ipr_w;
  logic [2:0] ipr_sel_w;
  logic [31:0] wmask_w;

  assign hit_setena_w = bus.addr == `NVU_OFF_SETENA; // R16
  assign hit_clrena_w = bus.addr == `NVU_OFF_CLRENA; // R16
  assign hit_setpend_w = bus.addr == `NVU_OFF_SETPEND; // R16
  assign hit_clrpend_w = bus.addr == `NVU_OFF_CLRPEND; // R16
  assign hit_active_w = bus.addr == `NVU_OFF_ACTIVE;
  assign hit_ipr_w = (bus.addr & `NVU_IPR_MASK) == `NVU_OFF_IPR; // R15
  assign ipr_sel_w = bus.addr[4:2];
  assign wmask_w = bus.wdata & ~`NVU_RSVD_MASK;

  logic [31:0] setena_w;
  logic [31:0] clrena_w;
  logic [31:0] setpend_w;
  logic [31:0] clrpend_w;

  assign setena_w = (bus.wr && hit_setena_w) ? wmask_w : 32'h00000000; // R7
  assign clrena_w = (bus.wr && hit_clrena_w) ? wmask_w : 32'h00000000; // R7
  assign setpend_w = (bus.wr && hit_setpend_w) ? wmask_w : 32'h00000000; // R12
  assign clrpend_w = (bus.wr && hit_clrpend_w) ? wmask_w : 32'h00000000; // R12

  ////////////////////////////////////////////////////////////////////////////
  // Core handshake.

  logic [4:0] ack_idx_w;
  logic accept_w;
  logic [31:0] ack_bit_w;
  logic [31:0] ret_bit_w;

  assign ack_idx_w = 5'(core_req_q.vec - `NVU_VEC_BASE);
  assign accept_w = ret.ack && core_req_q.req && en_q[ack_idx_w]; // R11
  assign ack_bit_w = accept_w ? (32'h00000001 << ack_idx_w) : 32'h00000000;
  assign ret_bit_w = ret.exc_ret ? (32'h00000001 << ret.ret_num) : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // State update; hardware sets win over clears.

  assign en_d = (en_q | setena_w) & ~clrena_w; // R7
  assign pend_d = (pend_q & ~clrpend_w & ~ack_bit_w) | setpend_w | (src_w & ~act_q); // R9 R12 R21
  assign act_d = (act_q & ~ret_bit_w) | ack_bit_w; // R10 R14

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_q <= `NVU_REG_RESET;
      pend_q <= `NVU_REG_RESET;
      act_q <= `NVU_REG_RESET;
    end else begin
      en_q <= en_d;
      pend_q <= pend_d;
      act_q <= act_d;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        pri_q[i] <= `NVU_PRI_RESET; // R17
      end
    end else if (bus.wr && hit_ipr_w) begin
      for (int k = 0; k < 4; k++) begin
        pri_q[{ipr_sel_w, 2'(k)}] <= bus.wdata[8 * k + `NVU_PRI_MSB -: 2]; // R15 R20
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  logic [31:0] ipr_word_w;
  logic [31:0] rd_val_w;

  always_comb begin
    ipr_word_w = 32'h00000000;
    for (int k = 0; k < 4; k++) begin
      ipr_word_w[8 * k + `NVU_PRI_MSB -: 2] = pri_q[{ipr_sel_w, 2'(k)}]; // R20
    end
  end

  assign rd_val_w = (hit_setena_w || hit_clrena_w) ? en_q : // R8
                    (hit_setpend_w || hit_clrpend_w) ? pend_q : // R13
                    hit_active_w ? act_q :
                    hit_ipr_w ? ipr_word_w :
                    32'h00000000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= bus.rd ? rd_val_w : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration and preemption on the next state.

  logic [31:0] cand_w;
  logic [2:0] run_prio_w;
  logic best_ok_w;
  logic [4:0] best_idx_w;
  logic [1:0] best_pri_w;
  logic req_w;
  logic [5:0] vec_w;
  nvu_core_req_t core_req_d;

  assign cand_w = pend_d & en_d & ~act_d; // R9 R11

  always_comb begin
    run_prio_w = `NVU_RUN_IDLE;
    for (int i = 0; i < 32; i++) begin
      if (act_d[i] && ({1'b0, pri_q[i]} < run_prio_w)) begin
        run_prio_w = {1'b0, pri_q[i]};
      end
    end
  end

  always_comb begin
    best_ok_w = 1'b0;
    best_idx_w = 5'h00;
    best_pri_w = 2'h3;
    for (int i = 0; i < 32; i++) begin
      if (cand_w[i] && (!best_ok_w || pri_q[i] < best_pri_w)) begin
        best_ok_w = 1'b1;
        best_idx_w = 5'(i);
        best_pri_w = pri_q[i];
      end
    end
  end

  assign req_w = best_ok_w && ({1'b0, best_pri_w} < run_prio_w) && !ret.sys_exc_active; // R18 R19
  assign vec_w = `NVU_VEC_BASE + {1'b0, best_idx_w}; // R1 R2

  always_comb begin
    core_req_d.req = req_w;
    core_req_d.vec = req_w ? vec_w : 6'h00;
    core_req_d.addr = req_w ? (`NVU_TBL_BASE + {24'h000000, vec_w, 2'b00}) : 32'h00000000; // R1
    core_req_d.prio = req_w ? best_pri_w : 2'h0;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_req_q <= '0;
    end else begin
      core_req_q <= core_req_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  logic [2:0] run_prio_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_prio_q <= `NVU_RUN_IDLE;
    end else begin
      run_prio_q <= run_prio_w;
    end
  end

  a_setena_sets: assert property (@(posedge core_clk) disable iff (rst) // R7
    bus.wr && hit_setena_w |=> ((en_q & $past(wmask_w)) == $past(wmask_w)))
    else $error("Set-enable write did not enable.");

  a_clrena_clears: assert property (@(posedge core_clk) disable iff (rst) // R7
    bus.wr && hit_clrena_w |=> ((en_q & $past(wmask_w)) == 32'h00000000)
      && ((en_q & ~$past(wmask_w)) == ($past(en_q) & ~$past(wmask_w))))
    else $error("Clear-enable write wrong.");

  a_enable_readback: assert property (@(posedge core_clk) disable iff (rst) // R8
    bus.rd && (hit_setena_w || hit_clrena_w) |=> rdata_q == $past(en_q))
    else $error("Enable readback wrong.");

  a_pend_readback: assert property (@(posedge core_clk) disable iff (rst) // R13
    bus.rd && (hit_setpend_w || hit_clrpend_w) |=> rdata_q == $past(pend_q))
    else $error("Pending readback wrong.");

  a_disabled_pends: assert property (@(posedge core_clk) disable iff (rst) // R9
    1'b1 |=> (pend_q & $past(src_w & ~act_q)) == $past(src_w & ~act_q))
    else $error("Asserted input did not pend.");

  a_no_disabled_act: assert property (@(posedge core_clk) disable iff (rst) // R11
    ret.ack |=> (act_q & ~$past(act_q) & ~$past(en_q)) == 32'h00000000)
    else $error("Disabled interrupt activated.");

  a_active_kept: assert property (@(posedge core_clk) disable iff (rst) // R10
    !ret.exc_ret |=> (act_q & $past(act_q)) == $past(act_q))
    else $error("Active state lost without return.");

  a_clrpend_active: assert property (@(posedge core_clk) disable iff (rst) // R14
    bus.wr && hit_clrpend_w && !ret.ack && !ret.exc_ret |=> act_q == $past(act_q))
    else $error("Clear-pending changed active state.");

  a_prio_low_zero: assert property (@(posedge core_clk) disable iff (rst) // R20
    bus.rd && hit_ipr_w |=> (rdata_q & 32'h3F3F3F3F) == 32'h00000000)
    else $error("Unimplemented priority bits read nonzero.");

  a_ack_unpends: assert property (@(posedge core_clk) disable iff (rst) // R21
    accept_w && !src_w[ack_idx_w] && !(bus.wr && hit_setpend_w)
      |=> !pend_q[$past(ack_idx_w)] && act_q[$past(ack_idx_w)])
    else $error("Accepted interrupt still pending.");

  a_strict_preempt: assert property (@(posedge core_clk) disable iff (rst) // R19
    core_req_q.req |-> ({1'b0, core_req_q.prio} < run_prio_q))
    else $error("Request without strictly higher priority.");

  a_vector_addr: assert property (@(posedge core_clk) disable iff (rst) // R1
    core_req_q.req |-> core_req_q.vec >= 6'h10 && core_req_q.vec <= 6'h2F
      && core_req_q.addr == {24'h000000, core_req_q.vec, 2'b00})
    else $error("Vector number or address wrong.");

  a_fixed_masks: assert property (@(posedge core_clk) disable iff (rst) // R18
    ret.sys_exc_active |=> !core_req_q.req)
    else $error("Request raised during fixed-priority exception.");

  a_rsvd_unused: assert property (@(posedge core_clk) disable iff (rst) // R3
    ((en_q | pend_q | act_q) & `NVU_RSVD_MASK) == 32'h00000000)
    else $error("Reserved interrupt bit set.");

  a_setpend_sets: assert property (@(posedge core_clk) disable iff (rst) // R12
    bus.wr && hit_setpend_w |=> ((pend_q & $past(wmask_w)) == $past(wmask_w)))
    else $error("Set-pending write did not pend.");

  a_clrpend_clears: assert property (@(posedge core_clk) disable iff (rst) // R12
    bus.wr && hit_clrpend_w |=> ((pend_q & $past(wmask_w & ~src_w)) == 32'h00000000))
    else $error("Clear-pending write did not clear.");

  a_prio_write: assert property (@(posedge core_clk) disable iff (rst) // R15
    bus.wr && hit_ipr_w |=> pri_q[{$past(ipr_sel_w), 2'b11}] == $past(bus.wdata[31:30]))
    else $error("Priority write not stored.");

  a_prio_readback: assert property (@(posedge core_clk) disable iff (rst) // R15
    bus.rd && hit_ipr_w |=> rdata_q[7:6] == $past(pri_q[{ipr_sel_w, 2'b00}]))
    else $error("Priority readback wrong.");

  a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst) // R16
    !bus.rd |=> rdata_q == 32'h00000000)
    else $error("Read data nonzero outside a read.");

  a_return_clears: assert property (@(posedge core_clk) disable iff (rst) // R10
    ret.exc_ret && !accept_w |=> !act_q[$past(ret.ret_num)])
    else $error("Exception return did not clear active.");

  a_lvd_routes: assert property (@(posedge core_clk) disable iff (rst) // R2
    src.low_voltage_detect_irq && !act_q[`NVU_BIT_LVD] |=> pend_q[`NVU_BIT_LVD])
    else $error("Low voltage request not pended.");

  a_serial_shared: assert property (@(posedge core_clk) disable iff (rst) // R3
    (src.serial0_irq || src.serial2_irq) && !act_q[`NVU_BIT_SERIAL] |=> pend_q[`NVU_BIT_SERIAL])
    else $error("Shared serial request not pended.");

  a_wake_routes: assert property (@(posedge core_clk) disable iff (rst) // R4
    src.power_down_wakeup_irq && !act_q[`NVU_BIT_PWRWU] |=> pend_q[`NVU_BIT_PWRWU])
    else $error("Wake-up request not pended.");

  a_clkfail_routes: assert property (@(posedge core_clk) disable iff (rst) // R5
    src.clock_fail_trim_irq && !act_q[`NVU_BIT_CLKFAIL] |=> pend_q[`NVU_BIT_CLKFAIL])
    else $error("Clock fail request not pended.");

  a_rtc_routes: assert property (@(posedge core_clk) disable iff (rst) // R6
    src.rtc_irq && !act_q[`NVU_BIT_RTC] |=> pend_q[`NVU_BIT_RTC])
    else $error("Real-time clock request not pended.");

  c_accept: cover property (@(posedge core_clk) disable iff (rst) accept_w);
  c_nested: cover property (@(posedge core_clk) disable iff (rst) accept_w && act_q != 32'h0);
  c_return: cover property (@(posedge core_clk) disable iff (rst) ret.exc_ret && act_q != 32'h0);
  c_sw_pend: cover property (@(posedge core_clk) disable iff (rst)
    bus.wr && hit_setpend_w ##[1:4] core_req_q.req);
  c_fixed_mask: cover property (@(posedge core_clk) disable iff (rst) ret.sys_exc_active && best_ok_w);

endmodule

`default_nettype wire

/* File: hw/nvu_pkg.sv */
package nvu_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } nvu_bus_t;

  typedef struct packed {
    logic low_voltage_detect_irq;
    logic window_watchdog_irq;
    logic serial0_irq;
    logic serial2_irq;
    logic power_down_wakeup_irq;
    logic clock_fail_trim_irq;
    logic rtc_irq;
    logic [31:0] other_irq;
  } nvu_src_t;

  typedef struct packed {
    logic ack;
    logic exc_ret;
    logic [4:0] ret_num;
    logic sys_exc_active;
  } nvu_core_ret_t;

  typedef struct packed {
    logic req;
    logic [5:0] vec;
    logic [31:0] addr;
    logic [1:0] prio;
  } nvu_core_req_t;

endpackage

/* File: hw/nvu_regs.svh */
`ifndef NVU_REGS_SVH
`define NVU_REGS_SVH

// Register byte offsets inside the system control block.
`define NVU_OFF_SETENA 12'h100
`define NVU_OFF_CLRENA 12'h180
`define NVU_OFF_SETPEND 12'h200
`define NVU_OFF_CLRPEND 12'h280
`define NVU_OFF_ACTIVE 12'h300
`define NVU_OFF_IPR 12'h400
`define NVU_IPR_MASK 12'hFE0

// Vector numbering and vector table.
`define NVU_VEC_BASE 6'h10
`define NVU_TBL_BASE 32'h00000000

// Source positions in the interrupt bit vector.
`define NVU_BIT_LVD 0
`define NVU_BIT_WDT 1
`define NVU_BIT_SERIAL 12
`define NVU_BIT_PWRWU 28
`define NVU_BIT_CLKFAIL 30
`define NVU_BIT_RTC 31
`define NVU_RSVD_MASK 32'h08B30000

// Priority fields and reset values.
`define NVU_PRI_MSB 7
`define NVU_PRI_RESET 2'h0
`define NVU_RUN_IDLE 3'h4
`define NVU_REG_RESET 32'h00000000

`endif

/* File: verification/nvu_core_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Core side: accepts an offered vector after dly cycles, returns on request.
module nvu_core_model
  import nvu_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire nvu_core_req_t core_req,
  input wire logic [1:0] dly,
  input wire logic do_ret,
  input wire logic [4:0] do_num,
  input wire logic busy,
  output nvu_core_ret_t ret
);
  logic [1:0] wait_q;
  logic take;

  assign take = core_req.req && !ret.ack;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ret <= '0;
      wait_q <= 2'h0;
    end else begin
      ret.exc_ret <= do_ret;
      ret.ret_num <= do_num;
      ret.sys_exc_active <= busy;
      ret.ack <= take && (wait_q >= dly);
      wait_q <= take ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

`default_nettype wire

/* File: verification/nvu_nested_vectored_irq_unit_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nvu_regs.svh"

module nvu_nested_vectored_irq_unit_tb
  import nvu_pkg::*;
();
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  nvu_bus_t bus = '0;
  logic [6:0] sv = 7'h0;
  logic [31:0] oth = 32'h0;
  logic busy = 1'b0;
  nvu_src_t src;
  logic [31:0] rdata_q;
  nvu_core_ret_t ret;
  nvu_core_req_t core_req_q;
  logic [1:0] dly = 2'h0;
  logic do_ret = 1'b0;
  logic [4:0] do_num = 5'h0;
  logic rd_d = 1'b0;
  logic [31:0] d;
  logic [31:0] m;
  logic [31:0] bm;
  int errors = 0;
  int checks_done = 0;
  int acks = 0;
  int n;
  logic [31:0] rq[$];
  logic [7:0] vq[$];
  int bit_of [7] = '{0, 1, 12, 12, 28, 30, 31};

  assign src = '{sv[0], sv[1], sv[2], sv[3], sv[4], sv[5], sv[6], oth};

  nvu_nested_vectored_irq_unit dut_u (.core_clk(core_clk), .rst(rst), .bus(bus),
    .rdata_q(rdata_q), .src(src), .ret(ret), .core_req_q(core_req_q));

  nvu_core_model core_u (.core_clk(core_clk), .rst(rst), .core_req(core_req_q), .dly(dly),
    .do_ret(do_ret), .do_num(do_num), .busy(busy), .ret(ret));

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input nvu_core_req_t got, input logic [7:0] e);
    checks_done++;
    if (got.req !== 1'b1 || got.vec !== e[5:0] || got.prio !== e[7:6]
        || got.addr !== {24'h0, e[5:0], 2'h0}) begin
      errors++;
      $display("Error %0t: vector %h expected %h", $time, got.vec, e[5:0]);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= v;
    @(posedge core_clk);
    bus.wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wait_ack;
    for (int k = 0; k < 20 && acks == n; k++) @(posedge core_clk);
    if (acks == n) begin
      errors++;
      $display("Error %0t: no acceptance", $time);
      test_done();
    end
  endtask

  task automatic ret_irq(input logic [4:0] num);
    do_ret <= 1'b1;
    do_num <= num;
    @(posedge core_clk);
    do_ret <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Results are compared mid-cycle, once the registered outputs have settled.
  always @(posedge core_clk) rd_d <= bus.rd;

  always @(negedge core_clk) begin
    if (rd_d === 1'b1) begin
      chk_word(rdata_q, rq.pop_front());
    end
    if (ret.ack === 1'b1) begin
      acks++;
      chk_vec(core_req_q, vq.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    d = $urandom(32'h8BC3958F);
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(`NVU_OFF_SETENA, 32'h0);
    rd(`NVU_OFF_IPR + 12'h00C, 32'h0);
    rd(12'h500, 32'h0);
    $display("test reset values done");
    d = $urandom & ~`NVU_RSVD_MASK;
    m = $urandom;
    wr(`NVU_OFF_SETENA, d);
    wr(`NVU_OFF_SETENA, 32'h0);
    rd(`NVU_OFF_SETENA, d);
    rd(`NVU_OFF_CLRENA, d);
    wr(`NVU_OFF_CLRENA, m);
    rd(`NVU_OFF_SETENA, d & ~m);
    wr(`NVU_OFF_CLRENA, 32'hFFFFFFFF);
    $display("test enable registers done");
    d = $urandom;
    wr(`NVU_OFF_SETPEND, d);
    wr(`NVU_OFF_CLRPEND, 32'h0);
    rd(`NVU_OFF_CLRPEND, d & ~`NVU_RSVD_MASK);
    wr(`NVU_OFF_CLRPEND, m);
    rd(`NVU_OFF_SETPEND, d & ~m & ~`NVU_RSVD_MASK);
    wr(`NVU_OFF_CLRPEND, 32'hFFFFFFFF);
    $display("test pending registers done");
    oth <= $urandom;
    @(posedge core_clk);
    bm = oth & ~`NVU_RSVD_MASK & 32'h2FFFEFFC;
    oth <= 32'h0;
    @(posedge core_clk);
    rd(`NVU_OFF_SETPEND, bm);
    wr(`NVU_OFF_CLRPEND, 32'hFFFFFFFF);
    $display("test other sources done");
    d = $urandom;
    wr(`NVU_OFF_IPR + 12'h01C, d);
    rd(`NVU_OFF_IPR + 12'h01C, d & 32'hC0C0C0C0);
    wr(`NVU_OFF_IPR + 12'h01C, 32'h0);
    $display("test priority fields done");
    for (int i = 0; i < 7; i++) begin
      bm = 32'h1 << bit_of[i];
      sv[i] <= 1'b1;
      @(posedge core_clk);
      sv[i] <= 1'b0;
      @(posedge core_clk);
      rd(`NVU_OFF_SETPEND, bm);
      rd(`NVU_OFF_ACTIVE, 32'h0);
      dly <= 2'($urandom);
      vq.push_back({2'h0, 6'(16 + bit_of[i])});
      n = acks;
      wr(`NVU_OFF_SETENA, bm);
      wait_ack();
      rd(`NVU_OFF_CLRPEND, 32'h0);
      wr(`NVU_OFF_CLRENA, bm);
      wr(`NVU_OFF_CLRPEND, bm);
      rd(`NVU_OFF_ACTIVE, bm);
      ret_irq(5'(bit_of[i]));
      rd(`NVU_OFF_ACTIVE, 32'h0);
    end
    $display("test source routing done");
    busy <= 1'b1;
    wr(`NVU_OFF_SETENA, 32'h00000004);
    wr(`NVU_OFF_SETPEND, 32'h00000004);
    repeat (4) @(posedge core_clk);
    rd(`NVU_OFF_ACTIVE, 32'h0);
    n = acks;
    vq.push_back({2'h0, 6'h12});
    busy <= 1'b0;
    wait_ack();
    rd(`NVU_OFF_ACTIVE, 32'h00000004);
    wr(`NVU_OFF_CLRENA, 32'hFFFFFFFF);
    ret_irq(5'h02);
    $display("test fixed priority mask done");
    wr(`NVU_OFF_IPR + 12'h008, 32'h00804080);
    wr(`NVU_OFF_SETENA, 32'h00000700);
    n = acks;
    vq.push_back({2'h2, 6'h18});
    wr(`NVU_OFF_SETPEND, 32'h00000100);
    wait_ack();
    wr(`NVU_OFF_SETPEND, 32'h00000400);
    repeat (6) @(posedge core_clk);
    rd(`NVU_OFF_ACTIVE, 32'h00000100);
    n = acks;
    vq.push_back({2'h1, 6'h19});
    wr(`NVU_OFF_SETPEND, 32'h00000200);
    wait_ack();
    rd(`NVU_OFF_ACTIVE, 32'h00000300);
    ret_irq(5'h09);
    rd(`NVU_OFF_SETPEND, 32'h00000400);
    n = acks;
    vq.push_back({2'h2, 6'h1A});
    ret_irq(5'h08);
    wait_ack();
    rd(`NVU_OFF_ACTIVE, 32'h00000400);
    ret_irq(5'h0A);
    wr(`NVU_OFF_CLRENA, 32'hFFFFFFFF);
    wr(`NVU_OFF_IPR + 12'h008, 32'h0);
    $display("test preemption done");
    test_done();
  end
endmodule

`default_nettype wire
